// *** logic/ieep_pkg.sv ***
// Shared constants, types and state records of the EEPROM access block
package ieep_pkg;
    // System clock rate and write cycle timing
    localparam int CLK_MHZ = 200;
    localparam int WRITE_TIME_US = 5;
    localparam int BUSY_W = 16;
    localparam logic [BUSY_W-1:0] WRITE_CYCLES =
        BUSY_W'(WRITE_TIME_US * CLK_MHZ);
    localparam logic [3:0] BYTE_BITS = 4'h8;

    ////////////////////////////////////////////////////////////////////////
    // Control byte codes (upper seven bits)
    localparam logic [6:0] CTRL_EE = 7'h57;
    localparam logic [6:0] CTRL_RT = 7'h6f;

    // Address map
    localparam logic [7:0] EE_TOP = 8'h7f;
    localparam logic [7:0] PROT_LO = 8'hf0;
    localparam logic [7:0] PROT_HI = 8'hf7;
    localparam logic [7:0] RT_TOP = 8'h1f;
    localparam logic [7:0] SRAM_LO = 8'h20;
    localparam logic [7:0] SRAM_TOP = 8'h5f;
    localparam logic [7:0] UNLOCK_ADDR = 8'h0f;
    localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
    localparam logic [15:0] ERASED_PAIR = 16'hffff;

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [3:0] {
        ST_IDLE, ST_CTRL, ST_ADDR, ST_WDATA, ST_ACK_CTRL, ST_ACK_WR,
        ST_RDATA, ST_RACK, ST_RLOAD
    } ieep_state_e;

    typedef enum logic [1:0] {LK_LOCKED, LK_HALF, LK_OPEN} ieep_lock_e;

    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
        logic sda;
    } ieep_link_ev_s;

    typedef struct packed {
        logic scl_m;
        logic scl_s;
        logic scl_p;
        logic sda_m;
        logic sda_s;
        logic sda_p;
        ieep_link_ev_s ev;
    } ieep_link_s;

    typedef struct packed {
        ieep_state_e st;
        logic [3:0] cnt;
        logic [7:0] shreg;
        logic ee;
        logic rw;
        logic [7:0] ptr;
        ieep_lock_e lock;
        logic [7:0][7:0] pbuf;
        logic [7:0] pbufv;
        logic [7:0][7:0] prot;
        logic [BUSY_W-1:0] busy;
        logic wbusy;
        logic sda_oe;
        logic sda_out;
    } ieep_core_s;
endpackage

// *** logic/ieep_link.sv ***
// Pin synchroniser and start, stop and clock edge detector of the link
`timescale 1ns/1ps
module ieep_link (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Link pins
    input wire logic i_scl,
    input wire logic i_sda,
    // Events
    output ieep_pkg::ieep_link_ev_s o_ev
);
    ieep_pkg::ieep_link_s r, next_r;

    // Two-stage sync, then one more stage to find edges
    always_comb begin
        next_r = r;
        next_r.scl_m = i_scl;
        next_r.scl_s = r.scl_m;
        next_r.scl_p = r.scl_s;
        next_r.sda_m = i_sda;
        next_r.sda_s = r.sda_m;
        next_r.sda_p = r.sda_s;
        next_r.ev.rise = r.scl_s & ~r.scl_p;
        next_r.ev.fall = ~r.scl_s & r.scl_p;
        // SDA moving while SCL stays high frames a transfer
        next_r.ev.start = r.scl_s & r.scl_p & r.sda_p & ~r.sda_s;
        next_r.ev.stop = r.scl_s & r.scl_p & ~r.sda_p & r.sda_s;
        next_r.ev.sda = r.sda_s;
    end

    // Idle bus is high, so the pins reset high to avoid a false edge
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r <= '0;
            r.scl_m <= 1'b1;
            r.scl_s <= 1'b1;
            r.scl_p <= 1'b1;
            r.sda_m <= 1'b1;
            r.sda_s <= 1'b1;
            r.sda_p <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign o_ev = r.ev;
endmodule

// *** logic/ieep_core.sv ***
// Client protocol engine: reads, page writes and the protected block
`timescale 1ns/1ps
module ieep_core #(
    parameter logic HAS_NODE_ID = 1'b1,
    // Arbitrary identifier values
    parameter logic [23:0] ORG_PREFIX = 24'h3c5a01,
    parameter logic [23:0] EXT_ID = 24'h000001
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Link pins
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    // Status
    output logic o_write_busy
);
    // Factory image of the protected block, lowest address in byte 0
    localparam logic [7:0][7:0] PROT_INIT = HAS_NODE_ID ?
        {EXT_ID[7:0], EXT_ID[15:8], EXT_ID[23:16],
         ORG_PREFIX[7:0], ORG_PREFIX[15:8], ORG_PREFIX[23:16],
         ieep_pkg::ERASED_PAIR} : '1;

    ieep_pkg::ieep_link_ev_s ev;
    ieep_pkg::ieep_core_s r, next_r;
    logic [7:0] mem [0:127];
    logic [7:0] rd_byte;
    logic addr_hit;
    logic commit_main;

    ////////////////////////////////////////////////////////////////////////
    // Next address with the per-block roll-over
    function automatic logic [7:0] step_addr(input logic ee,
                                             input logic [7:0] a);
        logic [7:0] n;
        n = a + 8'h01;
        if (ee) begin
            if (a == ieep_pkg::EE_TOP) n = 8'h00;
            else if (a == ieep_pkg::PROT_HI) n = ieep_pkg::PROT_LO;
        end else begin
            if (a == ieep_pkg::RT_TOP) n = 8'h00;
            else if (a == ieep_pkg::SRAM_TOP) n = ieep_pkg::SRAM_LO;
        end
        return n;
    endfunction

    // Legal locations of each space
    function automatic logic addr_valid(input logic ee,
                                        input logic [7:0] a);
        logic ok;
        if (ee) begin
            ok = (a <= ieep_pkg::EE_TOP) ||
                 (a >= ieep_pkg::PROT_LO && a <= ieep_pkg::PROT_HI);
        end else begin
            ok = (a <= ieep_pkg::SRAM_TOP);
        end
        return ok;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    ieep_link u_link (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_scl(i_scl),
        .i_sda(i_sda),
        .o_ev(ev)
    );

    assign addr_hit = addr_valid(r.ee, r.shreg);

    // Byte at the pointer; clock and SRAM contents are not held here
    always_comb begin
        rd_byte = 8'h00;
        if (r.ee) begin
            if (r.ptr <= ieep_pkg::EE_TOP) begin
                rd_byte = mem[r.ptr[6:0]];
            end else if (r.ptr >= ieep_pkg::PROT_LO &&
                         r.ptr <= ieep_pkg::PROT_HI) begin
                rd_byte = r.prot[r.ptr[2:0]];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Protocol engine
    always_comb begin
        next_r = r;
        commit_main = 1'b0;
        if (r.busy != '0) begin
            next_r.busy = r.busy - 1'b1;
        end
        if (ev.stop) begin
            next_r.st = ieep_pkg::ST_IDLE;
            next_r.sda_oe = 1'b0;
            if (r.ee && !r.rw && r.pbufv != 8'h00) begin
                // Page goes to the array only now; locked protected data
                // is dropped silently
                if (!r.ptr[7]) begin
                    commit_main = 1'b1;
                    next_r.busy = ieep_pkg::WRITE_CYCLES;
                end else if (r.lock == ieep_pkg::LK_OPEN) begin
                    for (int i = 0; i < 8; i++) begin
                        if (r.pbufv[i]) next_r.prot[i] = r.pbuf[i];
                    end
                    next_r.busy = ieep_pkg::WRITE_CYCLES;
                end
                next_r.lock = ieep_pkg::LK_LOCKED;
            end
            next_r.pbufv = 8'h00;
        end else if (ev.start) begin
            // A restart abandons any half-written page
            next_r.st = ieep_pkg::ST_CTRL;
            next_r.cnt = 4'h0;
            next_r.sda_oe = 1'b0;
            next_r.pbufv = 8'h00;
        end else begin
            case (r.st)
                ieep_pkg::ST_CTRL, ieep_pkg::ST_ADDR,
                ieep_pkg::ST_WDATA: begin
                    if (ev.rise) begin
                        next_r.shreg = {r.shreg[6:0], ev.sda};
                        next_r.cnt = r.cnt + 4'h1;
                    end else if (ev.fall && r.cnt == ieep_pkg::BYTE_BITS) begin
                        next_r.cnt = 4'h0;
                        next_r.st = ieep_pkg::ST_ACK_WR;
                        next_r.sda_oe = 1'b1;
                        if (r.st == ieep_pkg::ST_CTRL) begin
                            next_r.ee = (r.shreg[7:1] == ieep_pkg::CTRL_EE);
                            next_r.rw = r.shreg[0];
                            next_r.st = ieep_pkg::ST_ACK_CTRL;
                            if (!(r.shreg[7:1] == ieep_pkg::CTRL_RT ||
                                  (r.shreg[7:1] == ieep_pkg::CTRL_EE &&
                                   r.busy == '0))) begin
                                next_r.st = ieep_pkg::ST_IDLE;
                                next_r.sda_oe = 1'b0;
                            end
                        end else if (r.st == ieep_pkg::ST_ADDR) begin
                            if (addr_hit) begin
                                next_r.ptr = r.shreg;
                            end else begin
                                next_r.st = ieep_pkg::ST_IDLE;
                                next_r.sda_oe = 1'b0;
                            end
                        end else if (r.ee) begin
                            // Only the low three bits advance in a page
                            next_r.pbuf[r.ptr[2:0]] = r.shreg;
                            next_r.pbufv[r.ptr[2:0]] = 1'b1;
                            next_r.ptr[2:0] = r.ptr[2:0] + 3'h1;
                        end else begin
                            next_r.ptr = step_addr(1'b0, r.ptr);
                            next_r.lock = ieep_pkg::LK_LOCKED;
                            if (r.ptr == ieep_pkg::UNLOCK_ADDR) begin
                                if (r.shreg == ieep_pkg::UNLOCK_KEY1) begin
                                    next_r.lock = ieep_pkg::LK_HALF;
                                end else if (r.shreg ==
                                             ieep_pkg::UNLOCK_KEY2 &&
                                             r.lock == ieep_pkg::LK_HALF) begin
                                    next_r.lock = ieep_pkg::LK_OPEN;
                                end
                            end
                        end
                    end
                end
                ieep_pkg::ST_ACK_WR: begin
                    if (ev.fall) begin
                        next_r.sda_oe = 1'b0;
                        next_r.st = ieep_pkg::ST_WDATA;
                    end
                end
                ieep_pkg::ST_ACK_CTRL: begin
                    if (ev.fall && r.rw) begin
                        // First bit goes out as the ack is released
                        next_r.shreg = rd_byte;
                        next_r.sda_oe = ~rd_byte[7];
                        next_r.st = ieep_pkg::ST_RDATA;
                        next_r.lock = ieep_pkg::LK_LOCKED;
                    end else if (ev.fall) begin
                        next_r.sda_oe = 1'b0;
                        next_r.st = ieep_pkg::ST_ADDR;
                    end
                end
                ieep_pkg::ST_RDATA: begin
                    if (ev.fall) begin
                        if (r.cnt == ieep_pkg::BYTE_BITS - 4'h1) begin
                            next_r.cnt = 4'h0;
                            next_r.sda_oe = 1'b0;
                            next_r.st = ieep_pkg::ST_RACK;
                        end else begin
                            next_r.cnt = r.cnt + 4'h1;
                            next_r.shreg = {r.shreg[6:0], 1'b0};
                            next_r.sda_oe = ~r.shreg[6];
                        end
                    end
                end
                ieep_pkg::ST_RACK: begin
                    if (ev.rise) begin
                        next_r.ptr = step_addr(r.ee, r.ptr);
                        next_r.st = ev.sda ? ieep_pkg::ST_IDLE
                                           : ieep_pkg::ST_RLOAD;
                    end
                end
                ieep_pkg::ST_RLOAD: begin
                    if (ev.fall) begin
                        next_r.shreg = rd_byte;
                        next_r.sda_oe = ~rd_byte[7];
                        next_r.st = ieep_pkg::ST_RDATA;
                    end
                end
                default: next_r.st = ieep_pkg::ST_IDLE;
            endcase
        end
        next_r.wbusy = (next_r.busy != '0);
        next_r.sda_out = 1'b0;
    end

    // State register; the protected block comes up with its image
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r <= '0;
            r.prot <= PROT_INIT;
        end else begin
            r <= next_r;
        end
    end

    // Main array has no reset, like any real nonvolatile store
    always_ff @(posedge i_mclk) begin
        if (commit_main) begin
            for (int i = 0; i < 8; i++) begin
                if (r.pbufv[i]) mem[{r.ptr[6:3], 3'(i)}] <= r.pbuf[i];
            end
        end
    end

    assign o_sda_out = r.sda_out;
    assign o_sda_oe = r.sda_oe;
    assign o_write_busy = r.wbusy;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    a_ptr_wrap_top: assert property (
        r.st == ieep_pkg::ST_RACK && ev.rise && !ev.sda && r.ee &&
        r.ptr == ieep_pkg::EE_TOP |=> r.ptr == 8'h00 &&
        r.st == ieep_pkg::ST_RLOAD)
        else $error("pointer did not wrap to zero");
    a_ptr_load_addr: assert property (
        r.st == ieep_pkg::ST_ADDR && ev.fall && r.cnt == 4'h8 && addr_hit
        |=> r.ptr == $past(r.shreg) && r.sda_oe)
        else $error("address not loaded or not acked");
    a_nack_bad_addr: assert property (
        r.st == ieep_pkg::ST_ADDR && ev.fall && r.cnt == 4'h8 && !addr_hit
        |=> !r.sda_oe && r.st == ieep_pkg::ST_IDLE)
        else $error("invalid address was acked");
    a_ack_read_ctrl: assert property (
        r.st == ieep_pkg::ST_CTRL && ev.fall && r.cnt == 4'h8 &&
        r.shreg == {ieep_pkg::CTRL_RT, 1'b1}
        |=> r.sda_oe && r.rw ##1 r.st == ieep_pkg::ST_ACK_CTRL)
        else $error("read control byte not acked");
    a_busy_nack_ee: assert property (
        r.st == ieep_pkg::ST_CTRL && ev.fall && r.cnt == 4'h8 &&
        r.shreg[7:1] == ieep_pkg::CTRL_EE && r.busy != '0 |=> !r.sda_oe)
        else $error("EEPROM command acked while busy");
    a_stop_release: assert property (
        ev.stop |=> !r.sda_oe && r.st == ieep_pkg::ST_IDLE)
        else $error("data still driven after stop");
    a_unlock_order: assert property (
        r.lock == ieep_pkg::LK_OPEN && $past(r.lock) != ieep_pkg::LK_OPEN
        |-> $past(r.lock) == ieep_pkg::LK_HALF &&
            $past(r.shreg) == ieep_pkg::UNLOCK_KEY2)
        else $error("unlocked without the key order");
    a_relock_write: assert property (
        ev.stop && r.ee && !r.rw && r.pbufv != 8'h00
        |=> r.lock == ieep_pkg::LK_LOCKED)
        else $error("block not relocked after write");
    a_locked_ignore: assert property (
        ev.stop && r.ee && !r.rw && r.ptr[7] &&
        r.lock != ieep_pkg::LK_OPEN |=> r.prot == $past(r.prot))
        else $error("locked protected write took effect");
    a_unlock_reads_zero: assert property (
        r.st == ieep_pkg::ST_ACK_CTRL && ev.fall && r.rw && !r.ee &&
        r.ptr == ieep_pkg::UNLOCK_ADDR |=> r.sda_oe && r.shreg == 8'h00)
        else $error("unlock location read nonzero");
    a_ptr_step: assert property (
        r.st == ieep_pkg::ST_RACK && ev.rise
        |=> r.ptr == step_addr(r.ee, $past(r.ptr)))
        else $error("pointer did not advance after byte");
endmodule

// *** dv/ieep_host.sv ***
// Link host model: clocks the link and drives the data line
`timescale 1ns/1ps
module ieep_host (
    // Clock
    input wire logic i_mclk,
    // Link
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_oe
);
    ////////////////////////////////////////////////////////////////////////
    // Idle bus: clock parked high, data left to the pull-up
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
    end

    // Wait a number of system clock edges
    task automatic hc(input int n);
        repeat (n) @(posedge i_mclk);
    endtask

    // Start or repeated start: data falls while the clock is high
    task automatic start();
        o_sda_oe <= 1'b0;
        hc(4);
        o_scl <= 1'b1;
        hc(8);
        o_sda_oe <= 1'b1;
        hc(8);
        o_scl <= 1'b0;
        hc(4);
    endtask

    // Stop: data rises while the clock is high, then the bus idles
    task automatic stop();
        o_sda_oe <= 1'b1;
        hc(4);
        o_scl <= 1'b1;
        hc(8);
        o_sda_oe <= 1'b0;
        hc(8);
    endtask

    // One bit: data set in the low phase, sampled in mid high phase
    task automatic xbit(input logic b, output logic r);
        o_sda_oe <= ~b;
        hc(4);
        o_scl <= 1'b1;
        hc(4);
        r = i_sda;
        hc(4);
        o_scl <= 1'b0;
        hc(4);
    endtask

    // Byte out, most significant bit first; ack taken on ninth bit
    task automatic wbyte(input logic [7:0] d, output logic ak);
        logic r;
        for (int i = 7; i >= 0; i--) xbit(d[i], r);
        xbit(1'b1, r);
        ak = ~r;
    endtask

    // Byte in; ack asks for more, nack before stop ends the read
    task automatic rbyte(input logic nak, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) xbit(1'b1, d[i]);
        xbit(nak, r);
    endtask
endmodule

// *** dv/tb.sv ***
// Self-checking bench of the EEPROM access block
`timescale 1ns/1ps
module tb;
    localparam logic [23:0] ORG = 24'h1a2b3c; // Arbitrary value
    localparam logic [23:0] EXT = 24'h4d5e6f; // Arbitrary value
    // Host's 64-bit form of the identifier: 0xfffe between the halves
    localparam logic [63:0] NODE64 = {ORG, 16'hfffe, EXT};
    logic i_mclk;
    logic i_rst_n;
    logic scl;
    logic host_oe;
    logic sda_out;
    logic sda_oe;
    logic busy;
    logic [7:0] none[$];
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    // Open-drain wire: any party enabled pulls it, else the pull-up
    wire sda = ~host_oe & (sda_oe ? sda_out : 1'b1);

    ////////////////////////////////////////////////////////////////////////
    ieep_core #(.HAS_NODE_ID(1'b1), .ORG_PREFIX(ORG), .EXT_ID(EXT)) DUT (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda),
        .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_write_busy(busy));
    ieep_host host (.i_mclk(i_mclk), .i_sda(sda), .o_scl(scl),
        .o_sda_oe(host_oe));

    initial begin
        i_mclk = 1'b0;
        forever #2.5 i_mclk = ~i_mclk;
    end

    // Hang guard, well above the longest expected run
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Write transaction; ak reports the control and address acks
    task automatic wr(input logic [6:0] c, input logic [7:0] a,
                      input logic [7:0] d[$], output logic ak);
        logic k;
        host.start();
        host.wbyte({c, 1'b0}, ak);
        if (ak) host.wbyte(a, ak);
        if (ak) foreach (d[i]) host.wbyte(d[i], k);
        host.stop();
    endtask

    // Read, after loading the pointer when a is not negative
    task automatic rd(input logic [6:0] c, input int a,
                      input logic [7:0] e[$]);
        logic k;
        logic [7:0] q;
        if (a >= 0) begin
            host.start();
            host.wbyte({c, 1'b0}, k);
            host.wbyte(a[7:0], k);
        end
        host.start();
        host.wbyte({c, 1'b1}, k);
        chk({7'h0, k}, 8'h01, "read control ack");
        foreach (e[i]) begin
            host.rbyte(i == e.size() - 1, q);
            chk(q, e[i], "read data");
        end
        host.stop();
    endtask

    // Busy must match exp just after Stop, then end within bound
    task automatic commit(input logic exp);
        int n;
        chk({7'h0, busy}, {7'h0, exp}, "busy after stop");
        n = 0;
        while (busy === 1'b1 && n < 1200) begin
            @(posedge i_mclk);
            n++;
        end
        chk({7'h0, busy}, 8'h00, "busy ends");
    endtask

    // Two unlock writes, optionally split by another register write
    task automatic unlock(input logic [7:0] k1, input logic [7:0] k2,
                          input logic mid);
        logic ak;
        wr(7'h6f, 8'h0f, '{k1}, ak);
        if (mid) wr(7'h6f, 8'h20, '{8'h00}, ak);
        wr(7'h6f, 8'h0f, '{k2}, ak);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Pages, busy refusal, wrapping sequential and current reads
    task automatic t_page();
        logic ak;
        logic [7:0] q[$];
        for (int i = 0; i < 9; i++) q.push_back(8'h90 + 8'(i));
        wr(7'h57, 8'h78, q, ak);
        host.start();
        host.wbyte(8'hae, ak);
        host.stop();
        chk({7'h0, ak}, 8'h00, "busy ctrl refused");
        rd(7'h6f, 8'h00, '{8'h00});
        commit(1'b1);
        q.delete();
        for (int i = 0; i < 8; i++) q.push_back(8'h30 + 8'(i));
        wr(7'h57, 8'h00, q, ak);
        commit(1'b1);
        rd(7'h57, 8'h78, '{8'h98, 8'h91});
        rd(7'h57, 8'h7e, '{8'h96, 8'h97, 8'h30, 8'h31});
        rd(7'h57, -1, '{8'h32, 8'h33});
        wr(7'h6f, 8'h05, none, ak);
        rd(7'h57, -1, '{8'h35});
    endtask

    // Address acceptance at the edges of each space
    task automatic t_addr();
        logic ak;
        logic [15:0] t[6] = '{16'h5790, 16'h5780, 16'h6f60, 16'h57ef,
                              16'h57f7, 16'h6f5f};
        for (int i = 0; i < 6; i++) begin
            wr(t[i][14:8], t[i][7:0], none, ak);
            chk({7'h0, ak}, {7'h0, i > 3}, "address ack");
        end
        rd(7'h6f, 8'h0f, '{8'h00});
    endtask

    // Protected block contents, unlock order and relock
    task automatic t_prot();
        logic ak;
        rd(7'h57, 8'hf0, '{8'hff, 8'hff, NODE64[63:56], NODE64[55:48],
            NODE64[47:40], NODE64[23:16],
            NODE64[15:8], NODE64[7:0]});
        wr(7'h57, 8'hf0, '{8'h5a}, ak);
        commit(1'b0);
        unlock(8'haa, 8'h55, 1'b0);
        wr(7'h57, 8'hf0, '{8'h5a}, ak);
        commit(1'b0);
        unlock(8'h55, 8'haa, 1'b1);
        wr(7'h57, 8'hf0, '{8'h5a}, ak);
        commit(1'b0);
        rd(7'h57, 8'hf0, '{8'hff});
        unlock(8'h55, 8'haa, 1'b0);
        wr(7'h57, 8'hf0, '{8'h5a, 8'ha5}, ak);
        commit(1'b1);
        wr(7'h57, 8'hf0, '{8'h00}, ak);
        commit(1'b0);
        rd(7'h57, 8'hf0, '{8'h5a, 8'ha5});
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Main sequence: reset held 16 cycles, then each scenario
    initial begin
        i_rst_n = 1'b0;
        repeat (16) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        repeat (8) @(posedge i_mclk);
        t_page();
        $display("test page done");
        t_addr();
        $display("test addr done");
        t_prot();
        $display("test prot done");
        complete_run();
    end
endmodule
